// file: rtl/tbs_pkg.sv
// Constants and types for the trigger buffer sequencer.
// Assumes one 50 MHz clock domain and a synchronous active-low reset.
// How it works
// [R01] Fire on manual command or enabled input edge
// [R02] Run commands until delimiter or buffer end
// [R03] Buffers wrap back to their start
// [R04] Back-to-back delimiters run nothing
// [R05] Immediate delimiter raises a command error
// [R06] Manual selector 1 to 4 picks buffer
// [R07] One manual command gives one firing
// [R08] Linked breakpoint output acts as trigger
// [R09] Manual fire ignores port configuration
// [R10] Host separates sequences with delimiters
// [R11] Per-buffer pointer skips past the delimiter
package tbs_pkg;
  localparam int          NBUF      = 4;    // Trigger buffers
  localparam int          DEPTH     = 16;   // Commands per buffer
  localparam int          CW        = 16;   // Command word width
  localparam logic [15:0] DELIM_CMD = 16'hFFFF; // Delimiter code
  localparam logic [2:0]  SEL_MIN   = 3'h1; // Lowest manual selector
  localparam logic [2:0]  SEL_MAX   = 3'h4; // Highest manual selector
  // Sequencer states, Gray along idle-run-wait
  typedef enum logic [1:0]
  {
    TBS_IDLE = 2'b00,
    TBS_RUN  = 2'b01,
    TBS_WAIT = 2'b11
  } tbs_state_t;
endpackage

// file: rtl/tbs_sequencer.sv
// Trigger buffer sequencer: stores, fires and runs command sequences.
// Assumes the executor answers each command with a one-cycle done pulse.
`timescale 1ns/10ps
module tbs_sequencer
#(
  parameter int NBUF  = tbs_pkg::NBUF,
  parameter int DEPTH = tbs_pkg::DEPTH,
  parameter int CW    = tbs_pkg::CW
)
(
  // Clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            rstn_i,
  // Host command port
  input  wire logic            store_i,
  input  wire logic [1:0]      store_buf_i,
  input  wire logic [CW-1:0]   store_cmd_i,
  input  wire logic            imm_i,
  input  wire logic [CW-1:0]   imm_cmd_i,
  input  wire logic            man_trig_i,
  input  wire logic [2:0]      man_sel_i,
  // Trigger sources (pins)
  input  wire logic [NBUF-1:0] trig_pin_i,
  input  wire logic [NBUF-1:0] trig_en_i,
  input  wire logic [NBUF-1:0] bkpt_i,
  input  wire logic [NBUF-1:0] bkpt_link_i,
  // Executor port
  output logic                 exec_valid_o,
  output logic [CW-1:0]        exec_cmd_o,
  input  wire logic            exec_done_i,
  // Status
  output logic                 cmd_err_o,
  output logic                 busy_o
);
  localparam int AW = $clog2(DEPTH);

  // Pin synchronisers, two stages each
  logic [NBUF-1:0] trig_s1, trig_s2, trig_s3;
  logic [NBUF-1:0] bk_s1, bk_s2, bk_s3;
  // Buffer storage and pointers
  logic [CW-1:0] mem [NBUF][DEPTH];
  logic [AW:0]   fill [NBUF];     // Stored count
  logic [AW-1:0] ptr  [NBUF];     // Execution pointer
  logic [NBUF-1:0] pend, next_pend; // Fire requests waiting
  logic [NBUF-1:0] fire_set;        // New fire requests this cycle
  logic [NBUF-1:0] fire_take;       // Request taken by the scanner
  tbs_pkg::tbs_state_t state, next_state;
  logic [1:0]    cur, next_cur;
  logic          next_valid;
  logic [CW-1:0] next_cmd;
  logic          next_err;
  logic          adv;             // Pointer of cur steps
  logic          wrap;            // Pointer returns to zero

  // Synchronise trigger pins and breakpoints
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      trig_s1 <= '0;
      trig_s2 <= '0;
      trig_s3 <= '0;
      bk_s1   <= '0;
      bk_s2   <= '0;
      bk_s3   <= '0;
    end
    else
    begin
      // Third stage only remembers the last level for edge detect
      trig_s1 <= trig_pin_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      bk_s1   <= bkpt_i;
      bk_s2   <= bk_s1;
      bk_s3   <= bk_s2;
    end
  end

  // Storage write, and per-buffer pointer update
  genvar g;
  generate
    for (g = 0; g < NBUF; g++)
    begin : g_buf
      always_ff @(posedge sys_clk_i)
      begin
        if (!rstn_i)
        begin
          fill[g] <= '0;
          ptr[g]  <= '0;
        end
        else
        begin
          if (store_i && store_buf_i == g[1:0] && fill[g] < DEPTH)
          begin
            mem[g][fill[g][AW-1:0]] <= store_cmd_i;
            fill[g] <= fill[g] + 1'b1;
          end
          // Advance past each command or delimiter, wrap at end
          if (adv && cur == g[1:0])
            ptr[g] <= wrap ? '0 : ptr[g] + 1'b1; // R03 R11
        end
      end
    end
  endgenerate

  // Fire requests: rising edges, links, one per manual command
  always_comb
  begin
    // New requests; a set beats a take, so no command is lost
    fire_set = (trig_s2 & ~trig_s3 & trig_en_i) // R01
             | (bk_s2 & ~bk_s3 & bkpt_link_i);  // R08
    // Manual fire ignores trig_en_i entirely
    if (man_trig_i && man_sel_i >= tbs_pkg::SEL_MIN
        && man_sel_i <= tbs_pkg::SEL_MAX)
      fire_set[man_sel_i[1:0] - 2'h1] = 1'b1; // R06 R07 R09
    // Idle scanner takes the request of cur, empty buffers too
    fire_take = '0;
    if (state == tbs_pkg::TBS_IDLE && pend[cur])
      fire_take[cur] = 1'b1;
    next_pend = (pend & ~fire_take) | fire_set; // R07
  end

  // Sequencer: pick a buffer, run commands
  always_comb
  begin
    next_state = state;
    next_cur   = cur;
    next_valid = exec_valid_o;
    next_cmd   = exec_cmd_o;
    adv        = 1'b0;
    wrap       = 1'b0;
    unique case (state)
      tbs_pkg::TBS_IDLE:
      begin
        if (pend[cur] && fill[cur] != '0)
          next_state = tbs_pkg::TBS_RUN;
        else if (!pend[cur])
          next_cur = cur + 2'h1; // Round-robin scan
      end
      tbs_pkg::TBS_RUN:
      begin
        adv  = 1'b1;
        wrap = ({1'b0, ptr[cur]} + 1'b1) >= fill[cur];
        if (mem[cur][ptr[cur]] == tbs_pkg::DELIM_CMD)
          next_state = tbs_pkg::TBS_IDLE; // R02 R04
        else
        begin
          next_valid = 1'b1;
          next_cmd   = mem[cur][ptr[cur]];
          next_state = tbs_pkg::TBS_WAIT;
        end
      end
      tbs_pkg::TBS_WAIT:
      begin
        if (exec_done_i)
        begin
          next_valid = 1'b0;
          // Stop at buffer end: ptr is zero after a wrap
          next_state = (ptr[cur] == '0) ? tbs_pkg::TBS_IDLE
                                        : tbs_pkg::TBS_RUN; // R02
        end
      end
      default:
        next_state = tbs_pkg::TBS_IDLE;
    endcase
  end

  // Immediate delimiter is an error
  always_comb
  begin
    next_err = imm_i && imm_cmd_i == tbs_pkg::DELIM_CMD; // R05
  end

  // Register sequencer state and outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      state        <= tbs_pkg::TBS_IDLE;
      cur          <= '0;
      pend         <= '0;
      exec_valid_o <= 1'b0;
      exec_cmd_o   <= '0;
      cmd_err_o    <= 1'b0;
      busy_o       <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cur          <= next_cur;
      pend         <= next_pend;
      exec_valid_o <= next_valid;
      exec_cmd_o   <= next_cmd;
      cmd_err_o    <= next_err;
      busy_o       <= next_state != tbs_pkg::TBS_IDLE;
    end
  end

  // Delimiter never reaches the executor
  a_delim_blocked: assert property ( // R02
    @(posedge sys_clk_i) disable iff (!rstn_i)
    exec_valid_o |-> exec_cmd_o != tbs_pkg::DELIM_CMD)
    else $error("delimiter sent to executor");
  // Immediate delimiter flags error next cycle
  a_imm_error: assert property ( // R05
    @(posedge sys_clk_i) disable iff (!rstn_i)
    imm_i && imm_cmd_i == tbs_pkg::DELIM_CMD |=> cmd_err_o)
    else $error("immediate delimiter not flagged");
  // Manual command on selector 1 sets pending bit 0, even as it is taken
  a_man_pend: assert property ( // R06
    @(posedge sys_clk_i) disable iff (!rstn_i)
    man_trig_i && man_sel_i == tbs_pkg::SEL_MIN
    |=> pend[0])
    else $error("manual trigger lost");
  // Command held until done
  a_cmd_hold: assert property ( // R02
    @(posedge sys_clk_i) disable iff (!rstn_i)
    exec_valid_o && !exec_done_i |=> exec_valid_o && $stable(exec_cmd_o))
    else $error("command dropped before done");
  // Wrapped pointer is back at the buffer start
  a_wrap_zero: assert property ( // R03
    @(posedge sys_clk_i) disable iff (!rstn_i)
    state == tbs_pkg::TBS_RUN && wrap |=> ptr[cur] == '0)
    else $error("pointer did not wrap to start");
  // A delimiter ends the firing without offering a command
  a_delim_stop: assert property ( // R04
    @(posedge sys_clk_i) disable iff (!rstn_i)
    state == tbs_pkg::TBS_RUN && mem[cur][ptr[cur]] == tbs_pkg::DELIM_CMD
    |=> state == tbs_pkg::TBS_IDLE && !exec_valid_o)
    else $error("delimiter did not end the firing");
endmodule

// file: tb/tbs_exec_model.sv
// Executor model: takes each command offered by the sequencer.
// Assumes it sits on the executor port and shares the system clock.
`timescale 1ns/10ps
module tbs_exec_model
#(
  parameter int DLY = 2 // Cycles of work per command
)
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Executor port
  input  wire logic        valid_i,
  input  wire logic [15:0] cmd_i,
  output logic             done_o,
  // Log of what ran
  output logic [7:0]       count_o,
  output logic [15:0]      last_o
);
  logic [2:0] wait_cnt; // Work timer, slow answers need DLY above 0
  // One done pulse per offered command; done blocks a double take
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      done_o   <= 1'b0;
      count_o  <= 8'h00;
      last_o   <= 16'h0000;
      wait_cnt <= 3'h0;
    end
    else
    begin
      done_o <= 1'b0;
      if (valid_i && !done_o)
      begin
        if (wait_cnt == DLY[2:0])
        begin
          done_o   <= 1'b1;
          count_o  <= count_o + 8'h01;
          last_o   <= cmd_i;
          wait_cnt <= 3'h0;
        end
        else
          wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule

// file: tb/trigger_buffer_sequencer_tb.sv
// Testbench: loads buffers, fires them by every source, checks runs.
// Assumes the executor model answers each command after a short wait.
`timescale 1ns/10ps
module trigger_buffer_sequencer_tb;
  logic clk = 0, rstn = 0, st = 0, im = 0, mt = 0, ev, ed, ce, bz;
  logic [1:0]  sb = 0;
  logic [15:0] sc = 0, ic = 0, last;
  logic [2:0]  ms = 0;
  logic [3:0]  tp = 0, te = 0, bp = 0, bl = 0;
  logic [15:0] xc;
  logic [7:0]  n;
  int miscompares = 0, total_checks = 0;
  always #10 clk = ~clk;
  tbs_sequencer dut (.sys_clk_i(clk), .rstn_i(rstn), .store_i(st),
    .store_buf_i(sb), .store_cmd_i(sc), .imm_i(im), .imm_cmd_i(ic),
    .man_trig_i(mt), .man_sel_i(ms), .trig_pin_i(tp), .trig_en_i(te),
    .bkpt_i(bp), .bkpt_link_i(bl), .exec_valid_o(ev), .exec_cmd_o(xc),
    .exec_done_i(ed), .cmd_err_o(ce), .busy_o(bz));
  tbs_exec_model exe (.sys_clk_i(clk), .rstn_i(rstn), .valid_i(ev),
    .cmd_i(xc), .done_o(ed), .count_o(n), .last_o(last));
  // Compare and count
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Let a firing start, then wait for idle under a bound
  task settle;
    int i;
    i = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    while (bz !== 1'b0 && i < 80)
    begin
      @(negedge clk);
      i++;
    end
    // A hang counts as a mismatch
    if (i >= 80)
    begin
      miscompares++;
      $display("wrong value busy expected 0 seen %b", bz);
    end
    @(posedge clk);
  endtask
  // Outputs idle just after reset release
  task t_reset;
    @(negedge clk);
    chk("exec_valid", 16'h0000, {15'h0000, ev});
    chk("exec_cmd", 16'h0000, xc);
    chk("cmd_err", 16'h0000, {15'h0000, ce});
    chk("busy", 16'h0000, {15'h0000, bz});
    @(posedge clk);
    $display("reset state done");
  endtask
  // Manual fire; expect dn commands run, last one el
  task fire(input logic [2:0] s, input logic [7:0] dn, input logic [15:0] el);
    logic [7:0] n0;
    n0 = n;
    mt <= 1'b1;
    ms <= s;
    @(posedge clk);
    mt <= 1'b0;
    settle;
    chk("count", {8'h00, n0 + dn}, {8'h00, n});
    chk("last", el, last);
  endtask
  // Immediate command; count error pulses over three cycles
  task imm(input logic [15:0] c, input logic [15:0] e);
    logic [15:0] k;
    k = 16'h0000;
    im <= 1'b1;
    ic <= c;
    @(posedge clk);
    im <= 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      k = k + {15'h0000, ce};
    end
    @(posedge clk);
    chk("cmd_err", e, k);
  endtask
  // Buffer 0: two runs; 1: empty, empty, one; 3: one command
  logic [17:0] sc_tab [8] = '{18'h00A00, 18'h00B00, 18'h0FFFF,
    18'h00C00, 18'h1FFFF, 18'h1FFFF, 18'h10D00, 18'h30E00};
  task t_manual;
    foreach (sc_tab[i])
    begin
      st <= 1'b1;
      sb <= sc_tab[i][17:16];
      sc <= sc_tab[i][15:0];
      @(posedge clk);
    end
    st <= 1'b0;
    fire(3'h1, 8'h02, 16'h0B00);
    fire(3'h1, 8'h01, 16'h0C00);
    fire(3'h1, 8'h02, 16'h0B00);
    fire(3'h2, 8'h00, 16'h0B00);
    fire(3'h2, 8'h00, 16'h0B00);
    fire(3'h2, 8'h01, 16'h0D00);
    fire(3'h4, 8'h01, 16'h0E00);
    fire(3'h0, 8'h00, 16'h0E00);
    fire(3'h5, 8'h00, 16'h0E00);
    $display("manual firing done");
  endtask
  task t_pins;
    logic [7:0] n0;
    n0 = n;
    // Pin 3 rises but is not enabled: nothing may run
    te <= 4'h1;
    bl <= 4'h1;
    tp <= 4'h8;
    settle;
    chk("count", {8'h00, n0}, {8'h00, n});
    // Enabled pin 0 rises: buffer 0 runs its last sequence
    tp <= 4'h9;
    settle;
    chk("count", {8'h00, n0 + 8'h01}, {8'h00, n});
    chk("last", 16'h0C00, last);
    // Unlinked breakpoint 3 first, then linked breakpoint 0
    bp <= 4'h8;
    settle;
    chk("count", {8'h00, n0 + 8'h01}, {8'h00, n});
    bp <= 4'h9;
    settle;
    chk("count", {8'h00, n0 + 8'h03}, {8'h00, n});
    chk("last", 16'h0B00, last);
    $display("pin and breakpoint firing done");
  endtask
  task t_err;
    imm(16'hFFFF, 16'h0001);
    imm(16'h1234, 16'h0000);
    $display("immediate delimiter done");
  endtask
  // Single place where the run ends
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog far beyond the expected run of a few hundred cycles
  initial
  begin
    #400000;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_manual;
    t_pins;
    t_err;
    end_of_test;
  end
endmodule
